// ### dmacc_pkg.sv
// Package: register map, field positions and enumerations of the channel control block
package dmacc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_LO = 4'h0;
  localparam logic [3:0] ADDR_CTRL_HI = 4'h4;
  localparam logic [3:0] ADDR_STATUS  = 4'h8;
  localparam logic [3:0] ADDR_IRQMASK = 4'hc;

  // ----------------------------------------------------------------
  // Control field positions (low word)
  // ----------------------------------------------------------------
  localparam int BIT_DEST_BURST_BLOCK = 26;
  localparam int BIT_SRC_BURST_BLOCK  = 25;
  localparam int BIT_CHANNEL_RESET    = 24;
  localparam int BIT_BYTE_ORDER_SWAP  = 23;
  localparam int BIT_ACK_PIN_POLARITY = 22;
  localparam int BIT_REQ_PIN_POLARITY = 21;
  localparam int BIT_REQ_EDGE_DETECT  = 20;
  localparam int BIT_CHAIN_DONE_SEL   = 19;
  localparam int BIT_DONE_MODE_HI     = 18;
  localparam int BIT_DONE_MODE_LO     = 17;
  localparam int BIT_TRANSFER_ACTIVE  = 1;
  localparam int BIT_CHAIN_ENABLE     = 0;

  // Only bits 26:17 and the two flags are implemented
  localparam logic [31:0] CTRL_WR_MASK = 32'h07fe_0003;
  localparam logic [31:0] CTRL_RESET   = 32'h0100_0000;

  // Status bits: 0 request seen, 1 done seen, 2 transfer ended
  localparam int STAT_W = 3;
  localparam logic [STAT_W-1:0] STAT_RESET = 3'h0;

  localparam logic [1:0] DONE_IN_IGNORED = 2'h0;
  localparam logic [1:0] DONE_IN         = 2'h1;
  localparam logic [1:0] DONE_OUT        = 2'h2;
  localparam logic [1:0] DONE_OPEN_DRAIN = 2'h3;

  // Transfer size code: 8 bytes or more from this code upward
  localparam logic [2:0] TRANSFER_SIZE_FIELD_8BYTE = 3'h3;

  typedef enum logic {DMACC_SINGLE_ADDR, DMACC_DUAL_ADDR} dmacc_addr_mode_t;

endpackage : dmacc_pkg

// ### dmacc_pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
`default_nettype none

module dmacc_pin_sync
  import dmacc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  input  wire logic resetLevel,
  output logic      pinOut
);

  logic meta_q, s2_q, s3_q, out_q;
  logic out_d;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // Only the later two stages are compared; the first may be metastable
  always_comb begin
    out_d = out_q;
    if (s2_q == s3_q) begin
      out_d = s3_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      s2_q   <= 1'b1;
      s3_q   <= 1'b1;
      out_q  <= 1'b1;
    end else begin
      meta_q <= pinIn;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
      out_q  <= out_d;
    end
  end

  assign pinOut = out_q;

endmodule : dmacc_pin_sync
`default_nettype wire

// ### dmacc_channel_ctrl.sv
// Channel control bits 26:17 of one DMA channel, with pins and a register port
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Destination burst block splits writes into singles in dual mode
// - Source burst block splits reads into singles in dual mode
// - Channel reset clears flags, status, logic, request
// - Byte swap in dual mode, size eight+
// - Ack pin polarity follows its bit
// - Request pin polarity follows its bit
// - Request detect by edge or level
// - Done pin ends chain or current transfer
// - Done mode: ignored input, input, output, open-drain
module dmacc_channel_ctrl
  import dmacc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic [31:0]      regRdata,
  // Transfer engine side
  input  wire logic        dualAddrMode,
  input  wire logic [2:0]  transferSizeField,
  input  wire logic        ackActive,
  input  wire logic        driveDone,
  input  wire logic        transferEnd,
  input  wire logic        chainLast,
  input  wire logic [63:0] srcData,
  output logic [63:0]      dstData,
  output logic             srcBurstOk,
  output logic             dstBurstOk,
  output logic             reqEvent,
  output logic             busRequest,
  output logic             doneAbortChain,
  output logic             doneAbortCurrent,
  output logic             channelInReset,
  // Pins
  input  wire logic        channel_req_pin,
  output logic             channel_ack_pin,
  input  wire logic        transfer_done_pin_in,
  output logic             transfer_done_pin_out,
  output logic             transfer_done_pin_oe,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0]       ctrl_q, ctrl_d;
  logic [STAT_W-1:0] status_q, status_d;
  logic [STAT_W-1:0] mask_q, mask_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              reqSync, doneSync;
  logic              reqAsserted, reqPrev_q, reqPrev_d;
  logic              doneAsserted, donePrev_q, donePrev_d;
  logic [STAT_W-1:0] events;
  logic              chanRst;
  logic              doneIsInput;
  logic [63:0]       dst_q, dst_d;
  logic [63:0]       swapped;

  assign chanRst = ctrl_q[BIT_CHANNEL_RESET];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  dmacc_pin_sync u_req_sync (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .pinIn      (channel_req_pin),
    .resetLevel (1'b1),
    .pinOut     (reqSync)
  );

  dmacc_pin_sync u_done_sync (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .pinIn      (transfer_done_pin_in),
    .resetLevel (1'b1),
    .pinOut     (doneSync)
  );

  // ----------------------------------------------------------------
  // Request detection
  // ----------------------------------------------------------------
  // polarity select
  assign reqAsserted = ctrl_q[BIT_REQ_PIN_POLARITY] ? reqSync : ~reqSync;

  always_comb begin
    reqPrev_d = chanRst ? 1'b0 : reqAsserted;
    reqEvent  = 1'b0;
    if (!chanRst) begin
      if (ctrl_q[BIT_REQ_EDGE_DETECT]) begin
        reqEvent = reqAsserted & ~reqPrev_q;
      end else begin
        reqEvent = reqAsserted;
      end
    end
  end

  assign busRequest = reqEvent & ~chanRst;

  // ----------------------------------------------------------------
  // Acknowledge and done pins
  // ----------------------------------------------------------------
  // ack polarity
  assign channel_ack_pin = ctrl_q[BIT_ACK_PIN_POLARITY] ? (ackActive & ~chanRst)
                                                        : ~(ackActive & ~chanRst);

  always_comb begin
    transfer_done_pin_out = 1'b1;
    transfer_done_pin_oe  = 1'b0;
    doneIsInput           = 1'b0;
    case (ctrl_q[BIT_DONE_MODE_HI:BIT_DONE_MODE_LO])
      DONE_IN_IGNORED: begin
        doneIsInput = 1'b0;
      end
      DONE_IN: begin
        doneIsInput = 1'b1;
      end
      DONE_OUT: begin
        transfer_done_pin_oe  = ~chanRst;
        transfer_done_pin_out = ~driveDone;
      end
      default: begin
        // Open drain: only ever pulls low, and listens like an input
        transfer_done_pin_oe  = driveDone & ~chanRst;
        transfer_done_pin_out = 1'b0;
        doneIsInput           = 1'b1;
      end
    endcase
  end

  // Done pin is active low; own open-drain drive is masked only while the enable is on, not over the synchroniser delay after it
  assign doneAsserted = doneIsInput & ~doneSync & ~transfer_done_pin_oe & ~chanRst;
  assign donePrev_d   = doneAsserted;

  always_comb begin
    doneAbortChain   = 1'b0;
    doneAbortCurrent = 1'b0;
    if (doneAsserted && !donePrev_q) begin
      if (ctrl_q[BIT_CHAIN_DONE_SEL]) begin
        doneAbortChain = 1'b1;
      end else begin
        doneAbortCurrent = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Burst control
  // ----------------------------------------------------------------
  // destination and source burst blocks
  assign dstBurstOk = ~(dualAddrMode & ctrl_q[BIT_DEST_BURST_BLOCK]);
  assign srcBurstOk = ~(dualAddrMode & ctrl_q[BIT_SRC_BURST_BLOCK]);

  // ----------------------------------------------------------------
  // Byte order
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_swap
      assign swapped[gi*8 +: 8] = srcData[(7-gi)*8 +: 8];
    end
  endgenerate

  always_comb begin
    dst_d = srcData;
    if (ctrl_q[BIT_BYTE_ORDER_SWAP] && dualAddrMode && transferSizeField >= TRANSFER_SIZE_FIELD_8BYTE) begin
      dst_d = swapped;
    end
  end

  assign dstData = dst_q;

  // ----------------------------------------------------------------
  // Registers, status and interrupt
  // ----------------------------------------------------------------
  assign events = {transferEnd, doneAbortChain | doneAbortCurrent, reqEvent};

  always_comb begin
    ctrl_d   = ctrl_q;
    status_d = status_q;
    mask_d   = mask_q;
    rdata_d  = 32'h0000_0000;
    if (regWrite) begin
      if (regAddr == ADDR_CTRL_LO) begin
        ctrl_d = regWdata & CTRL_WR_MASK;
      end else if (regAddr == ADDR_STATUS) begin
        status_d = status_q & ~regWdata[STAT_W-1:0];
      end else if (regAddr == ADDR_IRQMASK) begin
        mask_d = regWdata[STAT_W-1:0];
      end
    end
    // Set wins over a write-one clear in the same cycle
    status_d = status_d | events;
    if (transferEnd && chainLast) begin
      ctrl_d[BIT_CHAIN_ENABLE] = 1'b0;
    end
    if (doneAbortChain) begin
      ctrl_d[BIT_CHAIN_ENABLE]    = 1'b0;
      ctrl_d[BIT_TRANSFER_ACTIVE] = 1'b0;
    end
    if (ctrl_d[BIT_CHANNEL_RESET]) begin
      ctrl_d[BIT_TRANSFER_ACTIVE] = 1'b0;
      ctrl_d[BIT_CHAIN_ENABLE]    = 1'b0;
      status_d                    = STAT_RESET;
    end
    if (regRead) begin
      if (regAddr == ADDR_CTRL_LO) begin
        rdata_d = ctrl_q;
      end else if (regAddr == ADDR_STATUS) begin
        rdata_d = {{(32-STAT_W){1'b0}}, status_q};
      end else if (regAddr == ADDR_IRQMASK) begin
        rdata_d = {{(32-STAT_W){1'b0}}, mask_q};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= CTRL_RESET;
      status_q   <= STAT_RESET;
      mask_q     <= STAT_RESET;
      rdata_q    <= 32'h0000_0000;
      reqPrev_q  <= 1'b0;
      donePrev_q <= 1'b0;
      dst_q      <= 64'h0;
    end else begin
      ctrl_q     <= ctrl_d;
      status_q   <= status_d;
      mask_q     <= mask_d;
      rdata_q    <= rdata_d;
      reqPrev_q  <= reqPrev_d;
      donePrev_q <= donePrev_d;
      dst_q      <= dst_d;
    end
  end

  assign regRdata       = rdata_q;
  // held off until software clears reset
  assign channelInReset = chanRst;
  assign irq            = |(status_q & mask_q) & ~chanRst;

endmodule : dmacc_channel_ctrl
`default_nettype wire

// ### dmacc_channel_ctrl_monitor.sv
// Port-level assertions for the channel control block
`timescale 1ns/1ps
`default_nettype none
module dmacc_channel_ctrl_monitor
  import dmacc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        dualAddrMode,
  input wire logic [2:0]  transferSizeField,
  input wire logic        ackActive,
  input wire logic        driveDone,
  input wire logic [63:0] srcData,
  input wire logic [63:0] dstData,
  input wire logic        srcBurstOk,
  input wire logic        dstBurstOk,
  input wire logic        reqEvent,
  input wire logic        busRequest,
  input wire logic        doneAbortChain,
  input wire logic        doneAbortCurrent,
  input wire logic        channel_req_pin,
  input wire logic        channel_ack_pin,
  input wire logic        transfer_done_pin_out,
  input wire logic        transfer_done_pin_oe,
  input wire logic        irq
);
  // Shadow of the control word, so the checks need no view inside
  logic [31:0] shadow_q;
  logic [31:0] shadow_d;
  always_comb begin
    shadow_d = shadow_q;
    if (regWrite && regAddr == ADDR_CTRL_LO) shadow_d = regWdata;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) shadow_q <= CTRL_RESET;
    else shadow_q <= shadow_d;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_dst_burst_block: assert property (dualAddrMode && shadow_q[26] |-> !dstBurstOk)
    else $error("destination burst not blocked");
  a_src_burst_block: assert property (dualAddrMode && shadow_q[25] |-> !srcBurstOk)
    else $error("source burst not blocked");
  a_reset_quiet: assert property (shadow_q[24] |-> !busRequest && !irq)
    else $error("activity during channel reset");
  a_byte_swap: assert property (shadow_q[23] && dualAddrMode &&
    transferSizeField >= TRANSFER_SIZE_FIELD_8BYTE |=> dstData == {<<8{$past(srcData)}})
    else $error("bytes not reversed");
  a_ack_polarity: assert property (!shadow_q[24] |->
    channel_ack_pin == (ackActive ~^ shadow_q[22]))
    else $error("ack pin polarity");
  // Margin beyond the four-cycle pin latency
  a_level_request: assert property (!shadow_q[24] && !shadow_q[20] &&
    channel_req_pin == shadow_q[21] [*6] |-> reqEvent)
    else $error("level request missed");
  a_edge_pulse: assert property (shadow_q[20] && reqEvent |=> !reqEvent)
    else $error("edge request longer than one cycle");
  a_done_output: assert property (shadow_q[18:17] == DONE_OUT |->
    transfer_done_pin_oe && transfer_done_pin_out == !driveDone)
    else $error("done output mode");
  a_done_drain: assert property (shadow_q[18:17] == DONE_OPEN_DRAIN |->
    transfer_done_pin_oe == driveDone && !transfer_done_pin_out)
    else $error("done open drain mode");
  a_done_ignored: assert property (shadow_q[18:17] == DONE_IN_IGNORED |->
    !doneAbortChain && !doneAbortCurrent)
    else $error("ignored done acted on");
  a_done_select: assert property (doneAbortChain || doneAbortCurrent |->
    doneAbortChain == shadow_q[19] && doneAbortChain != doneAbortCurrent)
    else $error("done scope wrong");
endmodule : dmacc_channel_ctrl_monitor
bind dmacc_channel_ctrl dmacc_channel_ctrl_monitor mon_u (.ref_clk, .rst_n, .regAddr,
  .regWdata, .regWrite, .dualAddrMode, .transferSizeField, .ackActive, .driveDone,
  .srcData, .dstData, .srcBurstOk, .dstBurstOk, .reqEvent, .busRequest, .doneAbortChain,
  .doneAbortCurrent, .channel_req_pin, .channel_ack_pin, .transfer_done_pin_out,
  .transfer_done_pin_oe, .irq);
`default_nettype wire

// ### dmacc_io_device.sv
// Model of the I/O device on the request and done pins
`timescale 1ns/1ps
`default_nettype none
module dmacc_io_device (
  input  wire logic reqOn,
  input  wire logic reqHigh,
  input  wire logic pullDone,
  input  wire logic doneOut,
  input  wire logic doneOe,
  output logic      reqPin,
  output logic      doneWire
);
  assign reqPin = reqOn ? reqHigh : !reqHigh;
  // open drain line with pull-up; either side may pull it low
  assign doneWire = !pullDone && !(doneOe && !doneOut);
endmodule : dmacc_io_device
`default_nettype wire

// ### dmacc_channel_ctrl_tb.sv
// Self-checking testbench for the channel control block
`timescale 1ns/1ps
`default_nettype none
module dmacc_channel_ctrl_tb
  import dmacc_pkg::*;
;
  logic ref_clk = 0, rst_n = 0, regWrite = 0, regRead = 0, dualAddrMode = 0;
  logic ackActive = 0, driveDone = 0, reqOn = 0, reqHigh = 0, pullDone = 0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata, rdVal;
  logic [2:0] transferSizeField = 3'h0;
  logic [63:0] srcData = 64'h0, dstData;
  logic srcBurstOk, dstBurstOk, reqEvent, busRequest, doneAbortChain, doneAbortCurrent;
  logic channelInReset, reqPin, ackPin, doneWire, doneOut, doneOe, irq;
  int err_total = 0, checks_done = 0, cycles = 0, nReq, nCh, nCur;
  always #10 ref_clk = !ref_clk;
  dmacc_channel_ctrl dut_u (.ref_clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .dualAddrMode, .transferSizeField, .ackActive, .driveDone,
    .transferEnd(1'b0), .chainLast(1'b0), .srcData, .dstData, .srcBurstOk, .dstBurstOk,
    .reqEvent, .busRequest, .doneAbortChain, .doneAbortCurrent, .channelInReset,
    .channel_req_pin(reqPin), .channel_ack_pin(ackPin), .transfer_done_pin_in(doneWire),
    .transfer_done_pin_out(doneOut), .transfer_done_pin_oe(doneOe), .irq);
  dmacc_io_device dev_u (.reqOn, .reqHigh, .pullDone, .doneOut, .doneOe, .reqPin, .doneWire);
  task automatic print_verdict;
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // Hang guard, far above the length of the sequence
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a; regWdata <= d; regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    regAddr <= a; regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 rdVal = regRdata;
  endtask : rd
  task automatic watch;
    nReq = 0; nCh = 0; nCur = 0;
    repeat (10) begin
      @(posedge ref_clk);
      #1 nReq += reqEvent; nCh += doneAbortChain; nCur += doneAbortCurrent;
    end
  endtask : watch
  task automatic t_reset;
    rd(ADDR_CTRL_LO); chk(rdVal, CTRL_RESET);
    rd(ADDR_CTRL_HI); chk(rdVal, 64'h0);
    rd(4'h2); chk(rdVal, 64'h0);
    reqOn <= 1'b1; watch(); chk(nReq, 0);
    rd(ADDR_STATUS); chk(rdVal, 64'h0);
    reqOn <= 1'b0;
  endtask : t_reset
  task automatic t_level;
    wr(ADDR_IRQMASK, 32'h0); wr(ADDR_CTRL_LO, 32'h0); reqOn <= 1'b1; watch();
    chk(busRequest, 1); chk(reqEvent, 1); chk(irq, 0);
    reqOn <= 1'b0; repeat (8) @(posedge ref_clk);
    wr(ADDR_IRQMASK, 32'h1); chk(irq, 1);
    wr(ADDR_STATUS, 32'h7); chk(irq, 0);
    reqHigh <= 1'b1; wr(ADDR_CTRL_LO, 32'h0030_0000); repeat (8) @(posedge ref_clk);
    reqOn <= 1'b1; watch(); chk(nReq, 1);
    reqOn <= 1'b0; watch(); chk(nReq, 0);
  endtask : t_level
  task automatic t_data;
    dualAddrMode <= 1'b1; transferSizeField <= TRANSFER_SIZE_FIELD_8BYTE;
    srcData <= 64'h0102_0304_0506_0708; wr(ADDR_CTRL_LO, 32'h0480_0000);
    // Data output is registered: the swap shows one cycle after the write lands
    @(posedge ref_clk); #1;
    chk(dstData, 64'h0807_0605_0403_0201); chk(dstBurstOk, 0); chk(srcBurstOk, 1);
    transferSizeField <= 3'h2; wr(ADDR_CTRL_LO, 32'h0200_0000);
    chk(dstData, 64'h0102_0304_0506_0708); chk(srcBurstOk, 0); chk(dstBurstOk, 1);
    dualAddrMode <= 1'b0; @(posedge ref_clk); #1 chk(srcBurstOk, 1);
  endtask : t_data
  task automatic t_pins;
    for (int p = 0; p < 2; p++) begin
      ackActive <= 1'b1; wr(ADDR_CTRL_LO, 32'(p) << 22); chk(ackPin, p);
      ackActive <= 1'b0; @(posedge ref_clk); #1 chk(ackPin, !p);
    end
    for (int m = 0; m < 8; m++) begin
      // Mode in bits 18:17, chain select in bit 19; engine never drives in open drain
      driveDone <= m[0] & !m[1]; wr(ADDR_CTRL_LO, 32'(m) << 17);
      pullDone <= 1'b1; watch(); pullDone <= 1'b0;
      chk(nCh, m[0] && m[2]);
      chk(nCur, m[0] && !m[2]);
      chk(doneOe, m[1:0] == 2'h2);
      chk(doneOut, m[1:0] != 2'h3);
      repeat (8) @(posedge ref_clk);
    end
    driveDone <= 1'b0; reqOn <= 1'b1; reqHigh <= 1'b0; wr(ADDR_CTRL_LO, 32'h0); watch();
    chk(busRequest, 1); wr(ADDR_CTRL_LO, CTRL_RESET); chk(busRequest, 0);
    chk(channelInReset, 1); chk(irq, 0); rd(ADDR_STATUS); chk(rdVal, 64'h0);
  endtask : t_pins
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_level();
    t_data();
    t_pins();
    print_verdict();
  end
endmodule : dmacc_channel_ctrl_tb
`default_nettype wire
